// ---- logic/adslu_pkg.sv ----
`default_nettype none

package adslu_pkg;

  // ==========================================================================
  // Operation select
  typedef enum logic [3:0] {
    ADSLU_OP_PLAIN_SUM,
    ADSLU_OP_FLAG_SUM,
    ADSLU_OP_SUM_WITH_CARRY_IN,
    ADSLU_OP_PLAIN_DIFFERENCE,
    ADSLU_OP_FLAG_SETTING_DIFFERENCE,
    ADSLU_OP_DIFFERENCE_WITH_BORROW,
    ADSLU_OP_NEGATE_FROM_ZERO,
    ADSLU_OP_BITWISE_CONJUNCTION,
    ADSLU_OP_BITWISE_INCLUSIVE_UNION,
    ADSLU_OP_BITWISE_EXCLUSIVE_UNION,
    ADSLU_OP_MASKED_CLEAR
  } adslu_op_type;

  // ==========================================================================
  // Widths and register indices
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned IDX_W    = 4;
  localparam int unsigned NUM_REGS = 16;
  localparam int unsigned ADDR_W   = 8;
  localparam logic [IDX_W-1:0] LOW_REG_LIMIT = 4'h8;
  localparam logic [IDX_W-1:0] STACK_POINTER_IDX   = 4'hD;
  localparam logic [IDX_W-1:0] PROGRAM_COUNTER_IDX = 4'hF;

  // ==========================================================================
  // Flag layout
  localparam int unsigned FLAG_N = 3;
  localparam int unsigned FLAG_Z = 2;
  localparam int unsigned FLAG_C = 1;
  localparam int unsigned FLAG_V = 0;
  localparam logic [3:0] FLAGS_RST = 4'h0;

  // ==========================================================================
  // Literal limits
  localparam logic [DATA_W-1:0] LIT_MAX_SMALL = 32'h0000_0007;
  localparam logic [DATA_W-1:0] LIT_MAX_BYTE  = 32'h0000_00FF;
  localparam logic [DATA_W-1:0] LIT_MAX_PTR   = 32'h0000_03FC;
  localparam logic [DATA_W-1:0] LIT_MAX_SP    = 32'h0000_01FC;
  localparam logic [1:0]        LIT_ALIGN_0   = 2'h0;

  // ==========================================================================
  // Controller register map (byte addresses)
  localparam logic [ADDR_W-1:0] REG_CMD      = 8'h00;
  localparam logic [ADDR_W-1:0] REG_LIT      = 8'h04;
  localparam logic [ADDR_W-1:0] REG_STATUS   = 8'h08;
  localparam logic [ADDR_W-1:0] REG_GPR_BASE = 8'h40;
  localparam logic [ADDR_W-1:0] REG_GPR_MASK = 8'hC3;

  // Command word fields
  localparam int unsigned CMD_OP_LSB    = 0;
  localparam int unsigned CMD_DST_LSB   = 4;
  localparam int unsigned CMD_SRC1_LSB  = 8;
  localparam int unsigned CMD_SRC2_LSB  = 12;
  localparam int unsigned CMD_DST_GIVEN = 16;
  localparam int unsigned CMD_USE_LIT   = 17;

  // Status word fields
  localparam int unsigned STAT_BUSY      = 0;
  localparam int unsigned STAT_REFUSED   = 1;
  localparam int unsigned STAT_FLAGS_LSB = 4;

endpackage : adslu_pkg

`default_nettype wire

// ---- logic/adslu_if.sv ----
`default_nettype none

interface adslu_if;
  import adslu_pkg::*;

  logic               req;
  adslu_op_type       op;
  logic [IDX_W-1:0]   dst_idx;
  logic               dst_given;
  logic [IDX_W-1:0]   src1_idx;
  logic [DATA_W-1:0]  src1_val;
  logic [DATA_W-1:0]  src2_val;
  logic [DATA_W-1:0]  lit_val;
  logic               use_lit;
  logic               res_valid;
  logic [IDX_W-1:0]   res_idx;
  logic [DATA_W-1:0]  res_val;
  logic [3:0]         flags;

  modport alu_end (
    input  req, op, dst_idx, dst_given, src1_idx, src1_val, src2_val,
    input  lit_val, use_lit,
    output res_valid, res_idx, res_val, flags
  );

  modport issue_end (
    output req, op, dst_idx, dst_given, src1_idx, src1_val, src2_val,
    output lit_val, use_lit,
    input  res_valid, res_idx, res_val, flags
  );

endinterface : adslu_if

`default_nettype wire

// ---- logic/adslu_alu_end.sv ----
`default_nettype none

module adslu_alu_end
  import adslu_pkg::*;
(
  input  wire logic   core_clk,
  input  wire logic   nrst,
  adslu_if.alu_end    link,
  output logic [3:0]  flags_nzcv
);

  // ==========================================================================
  // Operation decode
  function automatic logic op_is_difference(input adslu_op_type op);
    return (op == ADSLU_OP_PLAIN_DIFFERENCE) ||
           (op == ADSLU_OP_FLAG_SETTING_DIFFERENCE) ||
           (op == ADSLU_OP_DIFFERENCE_WITH_BORROW) ||
           (op == ADSLU_OP_NEGATE_FROM_ZERO);
  endfunction : op_is_difference

  function automatic logic op_uses_carry(input adslu_op_type op);
    return (op == ADSLU_OP_SUM_WITH_CARRY_IN) ||
           (op == ADSLU_OP_DIFFERENCE_WITH_BORROW);
  endfunction : op_uses_carry

  function automatic logic op_sets_nzcv(input adslu_op_type op);
    return (op == ADSLU_OP_FLAG_SUM) ||
           (op == ADSLU_OP_SUM_WITH_CARRY_IN) ||
           (op == ADSLU_OP_FLAG_SETTING_DIFFERENCE) ||
           (op == ADSLU_OP_DIFFERENCE_WITH_BORROW) ||
           (op == ADSLU_OP_NEGATE_FROM_ZERO);
  endfunction : op_sets_nzcv

  function automatic logic op_is_logic(input adslu_op_type op);
    return (op == ADSLU_OP_BITWISE_CONJUNCTION) ||
           (op == ADSLU_OP_BITWISE_INCLUSIVE_UNION) ||
           (op == ADSLU_OP_BITWISE_EXCLUSIVE_UNION) ||
           (op == ADSLU_OP_MASKED_CLEAR);
  endfunction : op_is_logic

  function automatic logic [DATA_W-1:0] logic_unit(
    input adslu_op_type      op,
    input logic [DATA_W-1:0] a,
    input logic [DATA_W-1:0] b
  );
    logic [DATA_W-1:0] r;
    r = '0;
    unique case (op)
      ADSLU_OP_BITWISE_CONJUNCTION:     r = a & b;
      ADSLU_OP_BITWISE_INCLUSIVE_UNION: r = a | b;
      ADSLU_OP_BITWISE_EXCLUSIVE_UNION: r = a ^ b;
      ADSLU_OP_MASKED_CLEAR:            r = a & ~b;
      default:                          r = '0;
    endcase
    return r;
  endfunction : logic_unit

  // ==========================================================================
  // State
  logic [3:0]        flags_q;
  logic [3:0]        flags_d;
  logic              res_valid_q;
  logic [IDX_W-1:0]  res_idx_q;
  logic [IDX_W-1:0]  res_idx_d;
  logic [DATA_W-1:0] res_val_q;
  logic [DATA_W-1:0] res_val_d;

  // ==========================================================================
  // Operand preparation
  wire logic              is_diff   = op_is_difference(link.op);
  wire logic              is_neg    = (link.op == ADSLU_OP_NEGATE_FROM_ZERO);
  wire logic              is_logic  = op_is_logic(link.op);
  wire logic              sets_nzcv = op_sets_nzcv(link.op);
  wire logic              sets_nz   = is_logic;

  // Second operand: register or literal
  wire logic [DATA_W-1:0] opnd_sel  =
    link.use_lit ? link.lit_val : link.src2_val;

  // Negate works as zero minus the first source
  wire logic [DATA_W-1:0] add_a     =
    is_neg ? '0 : link.src1_val;
  wire logic [DATA_W-1:0] raw_b     =
    is_neg ? link.src1_val : opnd_sel;

  // Subtraction as a + ~b + carry-in
  wire logic [DATA_W-1:0] add_b     =
    is_diff ? ~raw_b : raw_b;

  // Chained forms take the stored carry; a clear carry means borrow
  wire logic              carry_in  =
    op_uses_carry(link.op) ? flags_q[FLAG_C]
                           : is_diff;

  // ==========================================================================
  // Adder, 33 bits wide so the carry out is kept
  wire logic [DATA_W:0]   sum_wide  =
    {1'b0, add_a} + {1'b0, add_b} +
    {{DATA_W{1'b0}}, carry_in};
  wire logic [DATA_W-1:0] arith_res = sum_wide[DATA_W-1:0];
  wire logic [DATA_W-1:0] logic_res =
    logic_unit(link.op, link.src1_val, link.src2_val);

  // ==========================================================================
  // Flag terms
  wire logic              res_n     = res_val_d[DATA_W-1];
  wire logic              res_z     = (res_val_d == '0);
  wire logic              res_c     = sum_wide[DATA_W];
  // Overflow: equal operand signs giving a differing result sign
  wire logic              res_v     =
    (add_a[DATA_W-1] == add_b[DATA_W-1]) &&
    (arith_res[DATA_W-1] != add_a[DATA_W-1]);

  // ==========================================================================
  // Result and destination selection
  assign res_val_d = is_logic ? logic_res : arith_res;

  // Missing destination falls back on the first source
  assign res_idx_d = link.dst_given ? link.dst_idx
                                    : link.src1_idx;

  // Full update, N/Z only, or hold
  assign flags_d =
    sets_nzcv ? {res_n, res_z, res_c, res_v} :
    sets_nz   ? {res_n, res_z, flags_q[FLAG_C],
                 flags_q[FLAG_V]} :
                flags_q;

  // ==========================================================================
  // Registers
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      flags_q     <= FLAGS_RST;
      res_valid_q <= 1'b0;
      res_idx_q   <= '0;
      res_val_q   <= '0;
    end else begin
      res_valid_q <= link.req;
      if (link.req) begin
        res_idx_q <= res_idx_d;
        res_val_q <= res_val_d;
        flags_q   <= flags_d;
      end
    end
  end

  // ==========================================================================
  // Outputs
  assign link.res_valid = res_valid_q;
  assign link.res_idx   = res_idx_q;
  assign link.res_val   = res_val_q;
  assign link.flags     = flags_q;
  assign flags_nzcv     = flags_q;

endmodule : adslu_alu_end

`default_nettype wire

// ---- logic/adslu_issue_end.sv ----
`default_nettype none

module adslu_issue_end
  import adslu_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               nrst,
  adslu_if.issue_end              link,
  input  wire logic [ADDR_W-1:0]  avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [DATA_W-1:0]  avs_writedata,
  output logic [DATA_W-1:0]       avs_readdata,
  output logic                    avs_waitrequest
);

  // ==========================================================================
  // Operand legality
  function automatic logic is_low(input logic [IDX_W-1:0] r);
    return r < LOW_REG_LIMIT;
  endfunction : is_low

  function automatic logic cmd_legal(
    input adslu_op_type      op,
    input logic [IDX_W-1:0]  d,
    input logic [IDX_W-1:0]  s1,
    input logic [IDX_W-1:0]  s2,
    input logic              lit_en,
    input logic [DATA_W-1:0] lit
  );
    logic all_low;
    logic ok;
    all_low = is_low(d) && is_low(s1) && is_low(s2);
    ok      = 1'b0;
    unique case (op)
      ADSLU_OP_SUM_WITH_CARRY_IN, ADSLU_OP_DIFFERENCE_WITH_BORROW:
        ok = !lit_en && all_low && (d == s1);
      ADSLU_OP_NEGATE_FROM_ZERO:
        ok = !lit_en && is_low(d) && is_low(s1);
      ADSLU_OP_FLAG_SUM, ADSLU_OP_FLAG_SETTING_DIFFERENCE:
        ok = lit_en ? (is_low(d) && is_low(s1) &&
                       ((lit <= LIT_MAX_SMALL) ||
                        ((lit <= LIT_MAX_BYTE) && (d == s1))))
                    : all_low;
      ADSLU_OP_PLAIN_SUM:
        if (!lit_en) begin
          ok = (d == s1) && !((s1 == PROGRAM_COUNTER_IDX) &&
                              (s2 == PROGRAM_COUNTER_IDX));
        end else begin
          ok = (lit[1:0] == LIT_ALIGN_0) &&
               ((is_low(d) && ((s1 == STACK_POINTER_IDX) ||
                               (s1 == PROGRAM_COUNTER_IDX)) &&
                 (lit <= LIT_MAX_PTR)) ||
                ((d == STACK_POINTER_IDX) && (s1 == STACK_POINTER_IDX) &&
                 (lit <= LIT_MAX_SP)));
        end
      ADSLU_OP_PLAIN_DIFFERENCE:
        ok = lit_en && (lit[1:0] == LIT_ALIGN_0) &&
             (d == STACK_POINTER_IDX) && (s1 == STACK_POINTER_IDX) &&
             (lit <= LIT_MAX_SP);
      ADSLU_OP_BITWISE_CONJUNCTION, ADSLU_OP_BITWISE_INCLUSIVE_UNION,
      ADSLU_OP_BITWISE_EXCLUSIVE_UNION, ADSLU_OP_MASKED_CLEAR:
        ok = !lit_en && all_low && (d == s1);
      default:
        ok = 1'b0;
    endcase
    return ok;
  endfunction : cmd_legal

  // ==========================================================================
  // State
  logic [DATA_W-1:0] gpr_q [NUM_REGS];
  logic [DATA_W-1:0] lit_q;
  logic [DATA_W-1:0] cmd_q;
  logic              busy_q;
  logic              refused_q;
  logic              wait_q;
  logic [DATA_W-1:0] rdata_q;
  logic              req_q;
  adslu_op_type      op_q;
  logic [IDX_W-1:0]  dst_q;
  logic              dst_given_q;
  logic [IDX_W-1:0]  src1_q;
  logic [DATA_W-1:0] src1_val_q;
  logic [DATA_W-1:0] src2_val_q;
  logic [DATA_W-1:0] lit_val_q;
  logic              use_lit_q;

  // ==========================================================================
  // Bus decode; a request is held off while an operation is in flight
  wire logic             bus_req   = avs_read || avs_write;
  wire logic             accept    = bus_req && wait_q && !busy_q;
  wire logic             done      = bus_req && !wait_q;
  wire logic             wr_done   = done && avs_write;
  wire logic             hit_cmd   = (avs_address == REG_CMD);
  wire logic             hit_lit   = (avs_address == REG_LIT);
  wire logic             hit_stat  = (avs_address == REG_STATUS);
  wire logic             hit_gpr   =
    ((avs_address & REG_GPR_MASK) == REG_GPR_BASE);
  wire logic [IDX_W-1:0] gpr_sel   = avs_address[IDX_W+1:2];

  // Command fields
  wire adslu_op_type     c_op      =
    adslu_op_type'(avs_writedata[CMD_OP_LSB +: 4]);
  wire logic [IDX_W-1:0] c_dst     = avs_writedata[CMD_DST_LSB +: IDX_W];
  wire logic [IDX_W-1:0] c_src1    = avs_writedata[CMD_SRC1_LSB +: IDX_W];
  wire logic [IDX_W-1:0] c_src2    = avs_writedata[CMD_SRC2_LSB +: IDX_W];
  wire logic             c_dgiven  = avs_writedata[CMD_DST_GIVEN];
  wire logic             c_uselit  = avs_writedata[CMD_USE_LIT];
  // Legality is judged on the destination actually written
  wire logic [IDX_W-1:0] c_eff_dst = c_dgiven ? c_dst : c_src1;
  wire logic             issue     = wr_done && hit_cmd;
  wire logic             c_ok      =
    cmd_legal(c_op, c_eff_dst, c_src1, c_src2, c_uselit, lit_q);

  wire logic [DATA_W-1:0] stat_word =
    {{(DATA_W-8){1'b0}}, link.flags, 2'h0, refused_q, busy_q};

  wire logic [DATA_W-1:0] rdata_d  =
    hit_cmd  ? cmd_q :
    hit_lit  ? lit_q :
    hit_stat ? stat_word :
    hit_gpr  ? gpr_q[gpr_sel] : '0;

  // ==========================================================================
  // Bus slave
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      wait_q  <= 1'b1;
      rdata_q <= '0;
      lit_q   <= '0;
      cmd_q   <= '0;
    end else begin
      wait_q  <= !accept;
      rdata_q <= accept ? rdata_d : '0;
      if (wr_done && hit_lit) begin
        lit_q <= avs_writedata;
      end
      if (issue) begin
        cmd_q <= avs_writedata;
      end
    end
  end

  // ==========================================================================
  // Issue and write-back
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      busy_q      <= 1'b0;
      refused_q   <= 1'b0;
      req_q       <= 1'b0;
      op_q        <= ADSLU_OP_PLAIN_SUM;
      dst_q       <= '0;
      dst_given_q <= 1'b0;
      src1_q      <= '0;
      src1_val_q  <= '0;
      src2_val_q  <= '0;
      lit_val_q   <= '0;
      use_lit_q   <= 1'b0;
      for (int i = 0; i < NUM_REGS; i++) begin
        gpr_q[i] <= '0;
      end
    end else begin
      req_q <= issue && c_ok;
      if (issue) begin
        refused_q <= !c_ok;
      end
      if (issue && c_ok) begin
        busy_q      <= 1'b1;
        op_q        <= c_op;
        dst_q       <= c_dst;
        dst_given_q <= c_dgiven;
        src1_q      <= c_src1;
        src1_val_q  <= gpr_q[c_src1];
        src2_val_q  <= gpr_q[c_src2];
        lit_val_q   <= lit_q;
        use_lit_q   <= c_uselit;
      end
      if (link.res_valid) begin
        busy_q                <= 1'b0;
        gpr_q[link.res_idx]   <= link.res_val;
      end else if (wr_done && hit_gpr) begin
        gpr_q[gpr_sel]        <= avs_writedata;
      end
    end
  end

  // ==========================================================================
  // Outputs
  assign link.req        = req_q;
  assign link.op         = op_q;
  assign link.dst_idx    = dst_q;
  assign link.dst_given  = dst_given_q;
  assign link.src1_idx   = src1_q;
  assign link.src1_val   = src1_val_q;
  assign link.src2_val   = src2_val_q;
  assign link.lit_val    = lit_val_q;
  assign link.use_lit    = use_lit_q;
  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;

endmodule : adslu_issue_end

`default_nettype wire

// ---- sim/adslu_asserts.sv ----
`default_nettype none

module adslu_asserts
  import adslu_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              nrst,
  input wire logic              req,
  input wire adslu_op_type      op,
  input wire logic [IDX_W-1:0]  dst_idx,
  input wire logic              dst_given,
  input wire logic [IDX_W-1:0]  src1_idx,
  input wire logic [DATA_W-1:0] src1_val,
  input wire logic [DATA_W-1:0] src2_val,
  input wire logic [DATA_W-1:0] lit_val,
  input wire logic              use_lit,
  input wire logic              res_valid,
  input wire logic [IDX_W-1:0]  res_idx,
  input wire logic [DATA_W-1:0] res_val,
  input wire logic [3:0]        flags
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Reference arithmetic
  wire logic        is_neg = op == ADSLU_OP_NEGATE_FROM_ZERO;
  wire logic        is_sub = op inside {ADSLU_OP_PLAIN_DIFFERENCE,
    ADSLU_OP_FLAG_SETTING_DIFFERENCE, ADSLU_OP_DIFFERENCE_WITH_BORROW,
    ADSLU_OP_NEGATE_FROM_ZERO};
  wire logic        chain  = op inside {ADSLU_OP_SUM_WITH_CARRY_IN,
    ADSLU_OP_DIFFERENCE_WITH_BORROW};
  wire logic [31:0] opb    = use_lit ? lit_val : src2_val;
  wire logic [31:0] add_a  = is_neg ? 32'h0 : src1_val;
  wire logic [31:0] add_b  = is_neg ? ~src1_val : (is_sub ? ~opb : opb);
  wire logic        add_c  = chain ? flags[FLAG_C] : is_sub;
  wire logic [32:0] sum    = {1'h0, add_a} + {1'h0, add_b} + {32'h0, add_c};
  wire logic        ovf    = add_a[31] == add_b[31] && sum[31] != add_a[31];
  wire logic [31:0] ar_val = sum[31:0];
  wire logic [35:0] ar_all = {sum[31:0], sum[31], sum[31:0] == 32'h0,
    sum[32], ovf};
  wire logic        kept   = op inside {ADSLU_OP_PLAIN_SUM,
    ADSLU_OP_PLAIN_DIFFERENCE};
  wire logic        is_lg  = op inside {ADSLU_OP_BITWISE_CONJUNCTION,
    ADSLU_OP_BITWISE_INCLUSIVE_UNION, ADSLU_OP_BITWISE_EXCLUSIVE_UNION,
    ADSLU_OP_MASKED_CLEAR};
  wire logic [31:0] lg_res =
    op == ADSLU_OP_BITWISE_CONJUNCTION ? src1_val & src2_val :
    op == ADSLU_OP_BITWISE_INCLUSIVE_UNION ? src1_val | src2_val :
    op == ADSLU_OP_BITWISE_EXCLUSIVE_UNION ? src1_val ^ src2_val :
    src1_val & ~src2_val;
  wire logic [1:0]  lg_nz  = {lg_res[31], lg_res == 32'h0};
  wire logic [1:0]  cv     = flags[1:0];

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  sequence s_issue_kept;
    req && kept;
  endsequence
  sequence s_issue_logic;
    req && is_lg;
  endsequence

  answer_timing_a: assert property (req |=> res_valid)
    else $error("no result one cycle after request");
  result_origin_a: assert property (res_valid |-> $past(req))
    else $error("result without request");
  dest_explicit_a: assert property
    (req && dst_given |=> res_idx == $past(dst_idx))
    else $error("result index not the given destination");
  dest_default_a: assert property
    (req && !dst_given |=> res_idx == $past(src1_idx))
    else $error("result index not the first source");
  kept_flags_a: assert property
    (s_issue_kept |=> res_val == $past(ar_val) && $stable(flags))
    else $error("plain sum or difference wrong");
  sum_flags_a: assert property
    (req && op inside {ADSLU_OP_FLAG_SUM, ADSLU_OP_SUM_WITH_CARRY_IN}
     |=> {res_val, flags} == $past(ar_all))
    else $error("flag sum result or flags wrong");
  diff_flags_a: assert property
    (req && op inside {ADSLU_OP_FLAG_SETTING_DIFFERENCE,
     ADSLU_OP_DIFFERENCE_WITH_BORROW} |=> {res_val, flags} == $past(ar_all))
    else $error("flag difference result or flags wrong");
  negate_result_a: assert property
    (req && is_neg |=> {res_val, flags} == $past(ar_all))
    else $error("negate result or flags wrong");
  logic_value_a: assert property
    (s_issue_logic |=> res_val == $past(lg_res))
    else $error("logic result wrong");
  logic_flags_a: assert property
    (s_issue_logic |=> flags == {$past(lg_nz), $past(cv)})
    else $error("logic flags wrong");
  idle_hold_a: assert property
    (!req |=> !res_valid && $stable(flags) && $stable(res_val))
    else $error("result moved without request");

endmodule : adslu_asserts

`default_nettype wire

// ---- sim/add_sub_logic_alu_bench.sv ----
`default_nettype none

module add_sub_logic_alu_bench
  import adslu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              core_clk = 1'h0;
  logic              nrst = 1'h0;
  logic [ADDR_W-1:0] avs_address = 8'h00;
  logic              avs_read = 1'h0;
  logic              avs_write = 1'h0;
  logic [DATA_W-1:0] avs_writedata = 32'h0;
  logic [DATA_W-1:0] avs_readdata;
  logic              avs_waitrequest;
  logic [3:0]        flags_nzcv;
  logic [DATA_W-1:0] rd;
  int                err_total = 0;
  int                n_tests = 0;
  int                cyc_cnt = 0;

  always #5 core_clk = ~core_clk;

  adslu_if adslu_if_i ();

  adslu_issue_end adslu_issue_end_i (
    .core_clk        (core_clk),
    .nrst            (nrst),
    .link            (adslu_if_i),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest)
  );

  adslu_alu_end adslu_alu_end_i (
    .core_clk   (core_clk),
    .nrst       (nrst),
    .link       (adslu_if_i),
    .flags_nzcv (flags_nzcv)
  );

  adslu_asserts adslu_asserts_i (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .req       (adslu_if_i.req),
    .op        (adslu_if_i.op),
    .dst_idx   (adslu_if_i.dst_idx),
    .dst_given (adslu_if_i.dst_given),
    .src1_idx  (adslu_if_i.src1_idx),
    .src1_val  (adslu_if_i.src1_val),
    .src2_val  (adslu_if_i.src2_val),
    .lit_val   (adslu_if_i.lit_val),
    .use_lit   (adslu_if_i.use_lit),
    .res_valid (adslu_if_i.res_valid),
    .res_idx   (adslu_if_i.res_idx),
    .res_val   (adslu_if_i.res_val),
    .flags     (adslu_if_i.flags)
  );

  // ==========================================================================
  // Bus access and comparison
  task automatic final_report();
    if (err_total == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report

  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge core_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'h0) @(posedge core_clk);
    q = avs_readdata;
    avs_write <= 1'h0;
    avs_read  <= 1'h0;
  endtask : xfer

  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask : cmp_val

  task automatic cmp_nzcv(input logic [3:0] got, input logic [3:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: flags %h, expected %h", $time, got, exp);
    end
  endtask : cmp_nzcv

  function automatic logic [7:0] gpr(input logic [3:0] i);
    return REG_GPR_BASE | {2'h0, i, 2'h0};
  endfunction : gpr

  // Load operands, issue, wait on status, check flags and target
  task automatic do_row(input adslu_op_type op, input logic [3:0] d, s1, s2,
                        input logic dg, ul, rf, input logic [31:0] a, b, lit,
                        input logic [31:0] ev, input logic [3:0] ef);
    xfer(1'h1, gpr(s1), a, rd);
    xfer(1'h1, gpr(s2), b, rd);
    xfer(1'h1, REG_LIT, lit, rd);
    xfer(1'h1, REG_CMD, {14'h0, ul, dg, s2, s1, d, op}, rd);
    xfer(1'h0, REG_STATUS, 32'h0, rd);
    cmp_val(rd, {24'h0, ef, 2'h0, rf, 1'h0});
    cmp_nzcv(flags_nzcv, ef);
    xfer(1'h0, gpr(dg ? d : s1), 32'h0, rd);
    cmp_val(rd, ev);
  endtask : do_row

  always @(posedge core_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      err_total++;
      final_report();
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge core_clk);
    nrst <= 1'h1;
    cmp_nzcv(flags_nzcv, 4'h0);
    xfer(1'h0, REG_STATUS, 32'h0, rd);
    cmp_val(rd, 32'h0);
    xfer(1'h0, gpr(4'h5), 32'h0, rd);
    cmp_val(rd, 32'h0);
    xfer(1'h1, REG_STATUS, 32'hFF, rd);
    xfer(1'h0, REG_STATUS, 32'h0, rd);
    cmp_val(rd, 32'h0);
    xfer(1'h1, 8'h80, 32'h1234, rd);
    xfer(1'h0, 8'h80, 32'h0, rd);
    cmp_val(rd, 32'h0);
    do_row(ADSLU_OP_FLAG_SUM, 4'h0, 4'h0, 4'h2, 1'h1, 1'h0, 1'h0,
      32'hFFFFFFFF, 32'h1, 32'h0, 32'h0, 4'h6);
    do_row(ADSLU_OP_SUM_WITH_CARRY_IN, 4'h1, 4'h1, 4'h3, 1'h1, 1'h0, 1'h0,
      32'h1, 32'h2, 32'h0, 32'h4, 4'h0);
    do_row(ADSLU_OP_PLAIN_SUM, 4'h0, 4'h9, 4'hA, 1'h0, 1'h0, 1'h0,
      32'h7FFFFFFF, 32'h1, 32'h0, 32'h80000000, 4'h0);
    do_row(ADSLU_OP_FLAG_SUM, 4'h5, 4'h4, 4'h6, 1'h1, 1'h1, 1'h0,
      32'h7FFFFFFF, 32'h0, 32'h7, 32'h80000006, 4'h9);
    do_row(ADSLU_OP_FLAG_SETTING_DIFFERENCE, 4'h4, 4'h4, 4'h1, 1'h1, 1'h0,
      1'h0, 32'h0, 32'h1, 32'h0, 32'hFFFFFFFF, 4'h8);
    do_row(ADSLU_OP_DIFFERENCE_WITH_BORROW, 4'h5, 4'h5, 4'h2, 1'h1, 1'h0,
      1'h0, 32'h5, 32'h2, 32'h0, 32'h2, 4'h2);
    do_row(ADSLU_OP_DIFFERENCE_WITH_BORROW, 4'h6, 4'h6, 4'h3, 1'h1, 1'h0,
      1'h0, 32'h3, 32'h3, 32'h0, 32'h0, 4'h6);
    do_row(ADSLU_OP_NEGATE_FROM_ZERO, 4'h7, 4'h7, 4'h0, 1'h1, 1'h0, 1'h0,
      32'h80000000, 32'h0, 32'h0, 32'h80000000, 4'h9);
    do_row(ADSLU_OP_NEGATE_FROM_ZERO, 4'h2, 4'h3, 4'h0, 1'h1, 1'h0, 1'h0,
      32'h0, 32'h0, 32'h0, 32'h0, 4'h6);
    do_row(ADSLU_OP_PLAIN_DIFFERENCE, 4'hD, 4'hD, 4'h0, 1'h1, 1'h1, 1'h0,
      32'h100, 32'h0, 32'h8, 32'hF8, 4'h6);
    do_row(ADSLU_OP_BITWISE_CONJUNCTION, 4'h2, 4'h2, 4'h3, 1'h1, 1'h0, 1'h0,
      32'hF0F0F0F0, 32'hFF00FF00, 32'h0, 32'hF000F000, 4'hA);
    do_row(ADSLU_OP_BITWISE_INCLUSIVE_UNION, 4'h2, 4'h2, 4'h3, 1'h1, 1'h0,
      1'h0, 32'h0, 32'h0, 32'h0, 32'h0, 4'h6);
    do_row(ADSLU_OP_BITWISE_EXCLUSIVE_UNION, 4'h2, 4'h2, 4'h3, 1'h1, 1'h0,
      1'h0, 32'hA5A5A5A5, 32'h5A5A5A5A, 32'h0, 32'hFFFFFFFF, 4'hA);
    do_row(ADSLU_OP_MASKED_CLEAR, 4'h2, 4'h2, 4'h3, 1'h1, 1'h0, 1'h0,
      32'hFFFF0000, 32'hF00F0000, 32'h0, 32'h0FF00000, 4'h2);
    do_row(ADSLU_OP_SUM_WITH_CARRY_IN, 4'h1, 4'h2, 4'h3, 1'h1, 1'h0, 1'h1,
      32'h9, 32'h9, 32'h0, 32'h1, 4'h2);
    do_row(ADSLU_OP_FLAG_SUM, 4'h6, 4'h6, 4'h0, 1'h1, 1'h1, 1'h0,
      32'hFFFFFF01, 32'h0, 32'hFF, 32'h0, 4'h6);
    do_row(ADSLU_OP_PLAIN_SUM, 4'h3, 4'hD, 4'h0, 1'h1, 1'h1, 1'h0,
      32'h100, 32'h0, 32'h3FC, 32'h4FC, 4'h6);
    do_row(ADSLU_OP_PLAIN_SUM, 4'h3, 4'hD, 4'h0, 1'h1, 1'h1, 1'h1,
      32'h100, 32'h0, 32'h3FE, 32'h4FC, 4'h6);
    do_row(ADSLU_OP_FLAG_SETTING_DIFFERENCE, 4'h5, 4'h4, 4'h0, 1'h1, 1'h1,
      1'h1, 32'h9, 32'h0, 32'h8, 32'h2, 4'h6);
    final_report();
  end

endmodule : add_sub_logic_alu_bench

`default_nettype wire
